// ### rtl/ifbp_top.sv
// Pixel format, overlay blend and output packer with AHB-Lite registers
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "ifbp_cfg.svh"

module ifbp_top
  import ifbp_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        in_valid_i,
  input  wire ifbp_pix_s   in_pix_i,
  input  wire logic [31:0] ovl_word_i,
  output logic             in_ready_o,
  output logic             out_valid_o,
  output logic      [31:0] out_word_o,
  input  wire logic        out_ready_i,
  output ifbp_site_s       site_o,
  output logic      [2:0]  plane_o,
  output logic             filt_h_o,
  output logic             filt_v_o
);

  if (CNT_W < 1 || CNT_W > 16) begin : g_chk
    $error("ifbp_top: CNT_W must lie in 1..16");
  end

  logic [31:0]             ctrl;
  logic [31:0]             alpha_sw;
  logic [7:0]              alpha0;
  logic [7:0]              alpha1;
  logic                    wr_pend;
  logic [`IFBP_ADDR_W-1:0] wr_addr;
  logic                    start;
  logic [CNT_W-1:0]        pix_cnt;
  logic [CNT_W-1:0]        wrd_cnt;
  logic [`IFBP_BUF_W-1:0]  pbuf;
  logic [2:0]              pcnt;
  logic [1:0]              xpos;
  logic                    line_odd;

  ifbp_mode_e   mode;
  ifbp_infmt_e  infmt;
  ifbp_outfmt_e outfmt;
  ifbp_ovlfmt_e ovlfmt;
  logic         convert;
  logic         ovl_live;
  logic         accept;

  assign mode    = ifbp_mode_e'(ctrl[`IFBP_F_MODE]);
  assign infmt   = ifbp_infmt_e'(ctrl[`IFBP_F_INFMT]);
  assign outfmt  = ifbp_outfmt_e'(ctrl[`IFBP_F_OUTFMT]);
  assign ovlfmt  = ifbp_ovlfmt_e'(ctrl[`IFBP_F_OVLFMT]);
  assign convert = (mode == IFBP_CONVERT);
  // Overlay only reaches the blender on the PCI conversion path
  assign ovl_live = convert && ctrl[`IFBP_B_OVLEN]
                    && ctrl[`IFBP_B_PCI];
  assign accept  = in_valid_i && in_ready_o;

  // ---------------- AHB-Lite slave ----------------
  logic       addr_ok;
  logic [`IFBP_ADDR_W-1:0] a_addr;
  assign addr_ok = hsel_i && hready_i && htrans_i[`IFBP_HTRANS_ACT];
  assign a_addr  = haddr_i[`IFBP_ADDR_W-1:0];

  function automatic logic [31:0] read_mux(
    input logic [`IFBP_ADDR_W-1:0] addr
  );
    logic [31:0] rd;
    rd = 32'h0000_0000;
    if (addr == `IFBP_OFF_CTRL) begin
      rd = ctrl;
    end else if (addr == `IFBP_OFF_ALPHA) begin
      rd = alpha_sw;
    end else if (addr == `IFBP_OFF_STATUS) begin
      rd[`IFBP_F_STAT_PIX] = 16'(pix_cnt);
      rd[`IFBP_F_STAT_WRD] = 16'(wrd_cnt);
    end
    return rd;
  endfunction : read_mux

  // Zero wait states, OKAY only; unmapped addresses read zero
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (addr_ok && !hwrite_i) begin
      hrdata_o <= read_mux(a_addr);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else if (hready_i) begin
      wr_pend <= addr_ok && hwrite_i;
      wr_addr <= a_addr;
    end
  end

  assign start = wr_pend && (wr_addr == `IFBP_OFF_CTRL)
                 && hwdata_i[`IFBP_B_START];

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl     <= `IFBP_CTRL_RST;
      alpha_sw <= `IFBP_ALPHA_RST;
    end else if (wr_pend && wr_addr == `IFBP_OFF_CTRL) begin
      ctrl <= hwdata_i & `IFBP_CTRL_MASK;
    end else if (wr_pend && wr_addr == `IFBP_OFF_ALPHA) begin
      alpha_sw <= {16'h0000, hwdata_i[15:0]};
    end
  end

  // Active alpha codes change only when an operation starts
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      alpha0 <= 8'h00;
      alpha1 <= 8'h00;
    end else if (start) begin
      alpha0 <= alpha_sw[`IFBP_F_ALPHA0];
      alpha1 <= alpha_sw[`IFBP_F_ALPHA1];
    end
  end

  // ---------------- Overlay unpack ----------------
  logic [15:0] ovl_half;
  ifbp_tri_t   ovl_tri;
  ifbp_tri_t   mix_tri;
  logic [7:0]  eff_code;

  // Two-per-word overlays: even pixel takes the low half
  assign ovl_half = xpos[0] ? ovl_word_i[31:16] : ovl_word_i[15:0];

  always_comb begin
    ovl_tri  = '0;
    eff_code = 8'h00;
    case (ovlfmt)
      IFBP_OVL_RGB24A: begin
        eff_code   = ovl_word_i[31:24];
        ovl_tri[0] = ovl_word_i[23:16];
        ovl_tri[1] = ovl_word_i[15:8];
        ovl_tri[2] = ovl_word_i[7:0];
      end
      IFBP_OVL_RGB15A: begin
        eff_code   = ovl_half[15] ? alpha1 : alpha0;
        ovl_tri[0] = {ovl_half[14:10], ovl_half[14:12]};
        ovl_tri[1] = {ovl_half[9:5], ovl_half[9:7]};
        ovl_tri[2] = {ovl_half[4:0], ovl_half[4:2]};
      end
      IFBP_OVL_YUV422: begin
        // U alpha goes with Y0, V alpha with Y1
        eff_code   = (xpos[0] ? ovl_word_i[16] : ovl_word_i[0])
                     ? alpha1 : alpha0;
        ovl_tri[0] = xpos[0] ? ovl_word_i[31:24] : ovl_word_i[15:8];
        ovl_tri[1] = {ovl_word_i[7:1], 1'b0};
        ovl_tri[2] = {ovl_word_i[23:17], 1'b0};
      end
      default: begin
        eff_code = 8'h00;
      end
    endcase
    // No overlay path means pure image
    if (!ovl_live) begin
      eff_code = 8'h00;
    end
  end

  // Overlay family is software's choice; components blend as given
  ifbp_blend u_blend (
    .img_i  (in_pix_i.comp),
    .ovl_i  (ovl_tri),
    .code_i (eff_code),
    .mix_o  (mix_tri)
  );

  // ---------------- Pixel to bytes ----------------
  logic [31:0] pix_data;
  logic [2:0]  pix_n;
  logic [7:0]  cr;
  logic [7:0]  cg;
  logic [7:0]  cb;
  assign cr = mix_tri[0];
  assign cg = mix_tri[1];
  assign cb = mix_tri[2];

  always_comb begin
    pix_data = 32'h0000_0000;
    pix_n    = 3'd1;
    if (!convert) begin
      // One component per pass, one byte per sample
      pix_data[7:0] = in_pix_i.comp[0];
    end else begin
      case (outfmt)
        IFBP_OUT_233: begin
          pix_data[7:0] = {cr[7:6], cg[7:5], cb[7:5]};
        end
        IFBP_OUT_332: begin
          pix_data[7:0] = {cr[7:5], cg[7:5], cb[7:6]};
        end
        IFBP_OUT_RGB16: begin
          pix_data[15:0] = {cr[7:3], cg[7:2], cb[7:3]};
          pix_n          = 3'd2;
        end
        IFBP_OUT_RGB15A: begin
          pix_data[15:0] = {(eff_code != 8'h00), cr[7:3], cg[7:3],
                            cb[7:3]};
          pix_n          = 3'd2;
        end
        IFBP_OUT_RGB24A: begin
          pix_data = {eff_code, cr, cg, cb};
          pix_n    = 3'd4;
        end
        IFBP_OUT_RGB24P: begin
          pix_data[23:0] = {cr, cg, cb};
          pix_n          = 3'd3;
        end
        IFBP_OUT_YUV422: begin
          // Even pixel gives U0 Y0, odd gives V0 Y1
          pix_data[15:0] = xpos[0] ? {cr, cb} : {cr, cg};
          pix_n          = 3'd2;
        end
        default: begin
          pix_data[7:0] = cr;
        end
      endcase
    end
  end

  // ---------------- Byte packer ----------------
  logic [63:0] comb;
  logic [3:0]  total;
  assign comb  = {8'h00, pbuf} | (64'(pix_data) << {pcnt, 3'b000});
  assign total = 4'(pcnt) + 4'(pix_n);

  logic next_out_valid;
  always_comb begin
    next_out_valid = out_valid_o && !out_ready_i;
    if (accept && total >= `IFBP_WORD_BYTES) begin
      next_out_valid = 1'b1;
    end
  end

  // Low byte first: pixel 0 lands in bits 7-0
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || start) begin
      pbuf <= '0;
      pcnt <= 3'd0;
    end else if (accept && total >= `IFBP_WORD_BYTES) begin
      pcnt <= 3'(total - `IFBP_WORD_BYTES);
      pbuf <= `IFBP_BUF_W'(comb >> 32);
    end else if (accept) begin
      pbuf <= comb[`IFBP_BUF_W-1:0];
      pcnt <= total[2:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_word_o  <= 32'h0000_0000;
    end else begin
      out_valid_o <= next_out_valid;
      if (accept && total >= `IFBP_WORD_BYTES) begin
        out_word_o <= comb[31:0];
      end
    end
  end

  // One bubble per word: simple stall, nothing held beyond one word
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      in_ready_o <= 1'b0;
    end else begin
      in_ready_o <= !next_out_valid;
    end
  end

  // ---------------- Chroma siting ----------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || start) begin
      xpos     <= 2'd0;
      line_odd <= 1'b0;
    end else if (accept && in_pix_i.eol) begin
      xpos     <= 2'd0;
      line_odd <= !line_odd;
    end else if (accept) begin
      xpos <= xpos + 2'd1;
    end
  end

  ifbp_site_s next_site;
  always_comb begin
    next_site = '0;
    case (infmt)
      IFBP_IN_422_COS: begin
        next_site.chroma_step = (xpos[0] == 1'b0);
        next_site.chroma_line = 1'b1;
      end
      IFBP_IN_422_INT: begin
        next_site.chroma_step = (xpos[0] == 1'b0);
        next_site.midway      = 1'b1;
        next_site.chroma_line = 1'b1;
      end
      IFBP_IN_420_INT: begin
        // One chroma line per two luma lines
        next_site.chroma_step = (xpos[0] == 1'b0);
        next_site.midway      = 1'b1;
        next_site.chroma_line = !line_odd;
      end
      IFBP_IN_411_COS: begin
        next_site.chroma_step = (xpos == 2'd0);
        next_site.chroma_line = 1'b1;
      end
      default: begin
        next_site = '0;
      end
    endcase
  end

  // Plane tables: all three woven in conversion, else one selected for comp codes 0-2 and none for code 3
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      site_o   <= '0;
      plane_o  <= 3'b000;
      filt_h_o <= 1'b0;
      filt_v_o <= 1'b0;
    end else begin
      filt_h_o <= (mode == IFBP_FILT_H);
      filt_v_o <= (mode == IFBP_FILT_V);
      if (accept) begin
        site_o  <= convert ? next_site : '0;
        plane_o <= convert ? 3'b111
                   : 3'(3'b001 << ctrl[`IFBP_F_COMP]);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || start) begin
      pix_cnt <= '0;
    end else if (accept) begin
      pix_cnt <= pix_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || start) begin
      wrd_cnt <= '0;
    end else if (out_valid_o && out_ready_i) begin
      wrd_cnt <= wrd_cnt + CNT_W'(1);
    end
  end

  // ---------------- Checks ----------------
  default clocking cb_main @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_take_full;
    accept && convert && outfmt == IFBP_OUT_RGB24A && pcnt == 3'd0;
  endsequence
  sequence s_word_out;
    out_valid_o && out_word_o == $past(pix_data);
  endsequence

  chk_ovl_gate: assert property (accept && !ovl_live |-> mix_tri ==
    in_pix_i.comp) else $error("overlay merged off PCI path");
  chk_full_ovl: assert property (accept && eff_code >= `IFBP_A_FULL |->
    mix_tri == ovl_tri) else $error("full code not pure overlay");
  chk_word_24a: assert property (s_take_full |=> s_word_out)
    else $error("24+alpha word not emitted");
  chk_site_cos: assert property (accept && convert &&
    infmt == IFBP_IN_422_COS && xpos[0] == 1'b0 |=>
    site_o.chroma_step && !site_o.midway)
    else $error("co-sited step wrong");
  chk_site_mid: assert property (accept && convert &&
    (infmt == IFBP_IN_422_INT || infmt == IFBP_IN_420_INT) |=>
    site_o.midway) else $error("interspersed not midway");
  chk_site_411: assert property (accept && convert &&
    infmt == IFBP_IN_411_COS && xpos != 2'd0 |=> !site_o.chroma_step)
    else $error("4:1:1 step off grid");
  chk_alpha_load: assert property (start |=> alpha0 ==
    $past(alpha_sw[`IFBP_F_ALPHA0]) &&
    alpha1 == $past(alpha_sw[`IFBP_F_ALPHA1]))
    else $error("alpha codes not loaded");
  chk_plane_one: assert property (accept && !convert |=>
    $onehot(plane_o)) else $error("plane select not single");
  chk_out_hold: assert property (out_valid_o && !out_ready_i |=>
    out_valid_o && $stable(out_word_o) && !in_ready_o)
    else $error("output word dropped");

endmodule : ifbp_top

// ### rtl/ifbp_cfg.svh
// Register offsets, field positions, reset values and blend constants
`ifndef IFBP_CFG_SVH
`define IFBP_CFG_SVH

`define IFBP_ADDR_W      12
`define IFBP_OFF_CTRL    12'h000
`define IFBP_OFF_ALPHA   12'h004
`define IFBP_OFF_STATUS  12'h008

`define IFBP_CTRL_RST    32'h0000_0000
`define IFBP_ALPHA_RST   32'h0000_0000
`define IFBP_CTRL_MASK   32'h0000_1fff

`define IFBP_F_MODE      1:0
`define IFBP_F_COMP      3:2
`define IFBP_F_INFMT     5:4
`define IFBP_F_OUTFMT    8:6
`define IFBP_F_OVLFMT    10:9
`define IFBP_B_OVLEN     11
`define IFBP_B_PCI       12
`define IFBP_B_START     13
`define IFBP_F_ALPHA0    7:0
`define IFBP_F_ALPHA1    15:8
`define IFBP_F_STAT_PIX  15:0
`define IFBP_F_STAT_WRD  31:16

`define IFBP_HTRANS_ACT  1
`define IFBP_A_FULL      8'h80
`define IFBP_A_ONE       8'h80
`define IFBP_A_ROUND     16'h0040
`define IFBP_A_SHIFT     7

`define IFBP_WORD_BYTES  4'h4
`define IFBP_BUF_W       56

`endif

// ### rtl/ifbp_pkg.sv
// Types shared by the pixel format, blend and pack logic
package ifbp_pkg;

  typedef enum logic [1:0] {
    IFBP_FILT_H  = 2'b00,
    IFBP_FILT_V  = 2'b01,
    IFBP_CONVERT = 2'b10,
    IFBP_MOVE    = 2'b11
  } ifbp_mode_e;

  typedef enum logic [1:0] {
    IFBP_IN_422_COS = 2'b00,
    IFBP_IN_422_INT = 2'b01,
    IFBP_IN_420_INT = 2'b10,
    IFBP_IN_411_COS = 2'b11
  } ifbp_infmt_e;

  typedef enum logic [2:0] {
    IFBP_OUT_233    = 3'b000,
    IFBP_OUT_332    = 3'b001,
    IFBP_OUT_RGB16  = 3'b010,
    IFBP_OUT_RGB15A = 3'b011,
    IFBP_OUT_RGB24A = 3'b100,
    IFBP_OUT_RGB24P = 3'b101,
    IFBP_OUT_YUV422 = 3'b110
  } ifbp_outfmt_e;

  typedef enum logic [1:0] {
    IFBP_OVL_RGB24A = 2'b00,
    IFBP_OVL_RGB15A = 2'b01,
    IFBP_OVL_YUV422 = 2'b10
  } ifbp_ovlfmt_e;

  // Component order: 0 = R or Y, 1 = G or U, 2 = B or V
  typedef logic [2:0][7:0] ifbp_tri_t;

  typedef struct packed {
    logic      eol;
    ifbp_tri_t comp;
  } ifbp_pix_s;

  typedef struct packed {
    logic chroma_step;
    logic midway;
    logic chroma_line;
  } ifbp_site_s;

endpackage : ifbp_pkg

// ### rtl/ifbp_blend.sv
// Alpha blend of one overlay pixel into one image pixel
`timescale 1ns/10ps
`include "ifbp_cfg.svh"

module ifbp_blend
  import ifbp_pkg::*;
(
  input  wire ifbp_tri_t img_i,
  input  wire ifbp_tri_t ovl_i,
  input  wire logic [7:0] code_i,
  output ifbp_tri_t       mix_o
);

  logic [7:0] weight;
  logic [7:0] inv_weight;

  // Codes at or above the full mark saturate to pure overlay
  assign weight     = (code_i >= `IFBP_A_FULL) ? `IFBP_A_ONE : code_i;
  assign inv_weight = `IFBP_A_ONE - weight;

  for (genvar g = 0; g < 3; g++) begin : g_comp
    logic [15:0] sum;
    // Largest sum stays below 2^15, so no overflow
    assign sum = 16'(img_i[g]) * 16'(inv_weight)
               + 16'(ovl_i[g]) * 16'(weight) + `IFBP_A_ROUND;
    assign mix_o[g] = sum[`IFBP_A_SHIFT +: 8];
  end

endmodule : ifbp_blend

// ### verif/ifbp_sink.sv
// Model of the highway or PCI side that takes packed output words
`timescale 1ns/10ps

module ifbp_sink (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  input  wire logic        valid_i,
  input  wire logic [31:0] word_i,
  output logic             ready_o
);
  logic [1:0] gap;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap <= 2'h0;
    end else begin
      gap <= gap + 2'h1;
    end
  end

  // Slow mode takes one word in four cycles, so the packer must hold
  assign ready_o = !rst_i && (!slow_i || gap == 2'h3);
endmodule : ifbp_sink

// ### verif/test_image_format_blend_packer.sv
// Self-checking bench for the format, blend and pack block
`timescale 1ns/10ps

module test_image_format_blend_packer
  import ifbp_pkg::*;
;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end

  logic        ref_clk  = 1'h0;
  logic        rst      = 1'h1;
  logic        hsel     = 1'h0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'h0;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] hwdata   = 32'h0;
  logic        in_valid = 1'h0;
  ifbp_pix_s   in_pix   = 25'h0;
  logic [31:0] ovl      = 32'h0;
  logic        slow     = 1'h0;
  logic [31:0] hrdata;
  logic [31:0] out_word;
  logic        hreadyout;
  logic        hresp;
  logic        in_ready;
  logic        out_valid;
  logic        out_ready;
  logic        filt_h;
  logic        filt_v;
  ifbp_site_s  site;
  logic [2:0]  plane;
  logic [31:0] got[$];
  logic [7:0]  eb[$];
  logic [23:0] pix[4] = '{24'h10_80_f3, 24'h6c_2b_9e, 24'hff_00_55,
                          24'h01_c7_3a};
  int          errors = 0;
  int          n_compared = 0;

  always #4 ref_clk = ~ref_clk;

  ifbp_top #(.CNT_W(16)) ifbp_top_inst (
    .ref_clk_i(ref_clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .in_valid_i(in_valid),
    .in_pix_i(in_pix), .ovl_word_i(ovl), .in_ready_o(in_ready),
    .out_valid_o(out_valid), .out_word_o(out_word),
    .out_ready_i(out_ready), .site_o(site), .plane_o(plane),
    .filt_h_o(filt_h), .filt_v_o(filt_v));

  ifbp_sink ifbp_sink_inst (
    .clk_i(ref_clk), .rst_i(rst), .slow_i(slow), .valid_i(out_valid),
    .word_i(out_word), .ready_o(out_ready));

  always @(posedge ref_clk) begin
    if (out_valid === 1'h1 && out_ready === 1'h1) got.push_back(out_word);
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  task automatic hang();
    errors++;
    results();
  endtask : hang

  task automatic wait_hready();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (hreadyout !== 1'h1 && k < 64);
    if (hreadyout !== 1'h1) hang();
  endtask : wait_hready

  // Request is held until hready is seen high, then data phase follows
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'h1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_hready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_hready();
    rd = hrdata;
  endtask : ahb

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    ahb(1'h0, a, 32'h0, d);
    `CHK(d, e)
  endtask : rd_chk

  // Extra edge so the first pixel never meets the packer clear
  task automatic start(input logic [31:0] c);
    logic [31:0] d;
    ahb(1'h1, 32'h0, c | 32'h2000, d);
    @(posedge ref_clk);
    got.delete();
    eb.delete();
  endtask : start

  task automatic px(input logic [23:0] bgr, input logic eol,
                    input logic [31:0] ov);
    int k;
    in_valid <= 1'h1;
    in_pix   <= {eol, bgr};
    ovl      <= ov;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (in_ready !== 1'h1 && k < 200);
    if (in_ready !== 1'h1) hang();
  endtask : px

  task automatic drain();
    int k;
    k = 0;
    while (got.size() < eb.size() / 4 && k < 400) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 400) hang();
    for (int i = 0; i < eb.size() / 4; i++) begin
      `CHK(got[i], {eb[4*i+3], eb[4*i+2], eb[4*i+1], eb[4*i]})
    end
  endtask : drain

  function automatic void pack(input int f, input int x,
                               input logic [23:0] p, input logic [7:0] a);
    logic [7:0]  r;
    logic [7:0]  g;
    logic [7:0]  b;
    logic [15:0] h;
    {b, g, r} = p;
    h = {a != 8'h0, r[7:3], g[7:3], b[7:3]};
    if (f == 2) h = {r[7:3], g[7:2], b[7:3]};
    case (f)
      0: eb.push_back({r[7:6], g[7:5], b[7:5]});
      1: eb.push_back({r[7:5], g[7:5], b[7:6]});
      2, 3: begin
        eb.push_back(h[7:0]);
        eb.push_back(h[15:8]);
      end
      4, 5: begin
        eb.push_back(b);
        eb.push_back(g);
        eb.push_back(r);
        if (f == 4) eb.push_back(a);
      end
      6: begin
        eb.push_back(x % 2 ? b : g);
        eb.push_back(r);
      end
      default: eb.push_back(r);
    endcase
  endfunction : pack

  function automatic logic [7:0] mix(input logic [7:0] i, o, c);
    int w;
    w = c >= 8'h80 ? 128 : int'(c);
    return 8'((int'(i) * (128 - w) + int'(o) * w + 64) >> 7);
  endfunction : mix

  task automatic sc_regs();
    logic [31:0] d;
    rd_chk(32'h0, 32'h0);
    rd_chk(32'h4, 32'h0);
    rd_chk(32'h8, 32'h0);
    ahb(1'h1, 32'h0, 32'h1fff, d);
    rd_chk(32'h0, 32'h1fff);
    ahb(1'h1, 32'hc, 32'hffff_ffff, d);
    rd_chk(32'hc, 32'h0);
    `CHK(hresp, 1'h0)
    `CHK(hreadyout, 1'h1)
  endtask : sc_regs

  task automatic sc_modes();
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 3; c++) begin
        start(32'(m) | 32'(c << 2));
        // Plane select follows an accepted pixel, one edge late
        px(pix[0], 1'h0, 32'h0);
        in_valid <= 1'h0;
        @(posedge ref_clk);
        `CHK({filt_h, filt_v, plane}, {m == 0, m == 1, m == 2 ? 3'h7 : 3'(1 << c)})
      end
    end
    start(32'h7);
    for (int x = 0; x < 4; x++) begin
      px(pix[x], 1'h0, 32'h0);
      pack(-1, x, pix[x], 8'h0);
    end
    in_valid <= 1'h0;
    drain();
    rd_chk(32'h8, 32'h0001_0004);
  endtask : sc_modes

  task automatic sc_formats();
    for (int f = 0; f < 7; f++) begin
      slow <= f[0];
      start(32'h2 | 32'(f << 6));
      for (int x = 0; x < 4; x++) begin
        px(pix[x], 1'h0, 32'h0);
        pack(f, x, pix[x], 8'h0);
      end
      in_valid <= 1'h0;
      drain();
    end
    slow <= 1'h0;
  endtask : sc_formats

  task automatic sc_blend();
    logic [7:0] codes[7] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h80, 8'hff, 8'h13};
    logic [7:0] a;
    for (int p = 1; p >= 0; p--) begin
      start(32'h0902 | 32'(p << 12));
      for (int i = 0; i < 7; i++) begin
        px(24'h10_64_c8, 1'h0, {codes[i], 24'h20_f0_80});
        a = p ? codes[i] : 8'h0;
        pack(4, i, {mix(8'h10, 8'h80, a), mix(8'h64, 8'hf0, a),
                    mix(8'hc8, 8'h20, a)}, a);
      end
      in_valid <= 1'h0;
      drain();
    end
  endtask : sc_blend

  // Alpha codes must come from the copy latched at start
  task automatic sc_ovl15();
    logic [31:0] d;
    ahb(1'h1, 32'h4, 32'h8000, d);
    start(32'h1b02);
    ahb(1'h1, 32'h4, 32'h0080, d);
    px(pix[0], 1'h0, {1'h0, 15'h7fff, 1'h1, 5'h11, 5'h0a, 5'h03});
    px(pix[1], 1'h0, {1'h0, 15'h7fff, 1'h1, 5'h11, 5'h0a, 5'h03});
    in_valid <= 1'h0;
    pack(4, 0, 24'h18_52_8c, 8'h80);
    pack(4, 1, pix[1], 8'h00);
    drain();
  endtask : sc_ovl15

  task automatic sc_site();
    for (int f = 0; f < 4; f++) begin
      start(32'h2 | 32'(f << 4));
      for (int x = 0; x < 6; x++) begin
        px(pix[x % 4], x == 3, 32'h0);
        in_valid <= 1'h0;
        #1;
        `CHK(site.chroma_step, f == 3 ? x % 4 == 0 : x % 2 == 0)
        `CHK(site.midway, f == 1 || f == 2)
        if (f == 2) `CHK(site.chroma_line, x < 4)
        @(posedge ref_clk);
      end
    end
  endtask : sc_site

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    sc_regs();
    sc_modes();
    sc_formats();
    sc_blend();
    sc_ovl15();
    sc_site();
    results();
  end
endmodule : test_image_format_blend_packer
